// File: hw/rx_clock_generation.sv
// clock generation: gated external clock, base tick, range tick, feedback divider
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

// How it works
// - select code 00 stops the external clock and holds it low.
// - codes 01, 10, 11 divide the reference by 3, 6 and 12.
// - external clock runs in standby and active modes alike.
// - high and low halves are equal for every division ratio.
// - amplitude-good flag rises a fixed start-up time after oscillator start.
// - clock released only with amplitude good and a non-off select code.
// - clock release also needs the logic supply to be good.
// - base tick is the reference divided by 16.
// - range tick lasts 8, 4, 2 or 1 base ticks for ranges 0..3.
// - base and range ticks time debounce and receive path start-up.
// - feedback divider divides the local oscillator by 24 or by 32.
// - receive-enable and enable both low stop the oscillator and clock.
// - enable high with receive-enable low gives standby, path disabled.
module rx_clock_generation
    import rx_clk_pkg::*;
#(
    parameter logic [15:0] OSC_GOOD_CLKS_P = 16'(OSC_GOOD_CLKS)
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // mode and select pins
    input wire logic rx_en_i,
    input wire logic enable_i,
    input wire logic logic_supply_ok_i,
    input wire logic ext_div_sel0_i,
    input wire logic ext_div_sel1_i,
    input wire logic rate_sel0_i,
    input wire logic rate_sel1_i,
    // synthesizer
    input wire logic local_osc_tick_i,
    output logic fb_tick_o,
    // clocks and status out
    output logic crystal_osc_en_o,
    output logic osc_amplitude_good_o,
    output logic rx_path_en_o,
    output logic ext_clk_o,
    output logic base_tick_o,
    output logic range_tick_o
);

    // power mode
    power_mode_t mode_r;
    power_mode_t mode_nxt;
    logic osc_on;

    // oscillator start-up
    logic [15:0] osc_cnt_r;
    logic [15:0] osc_cnt_nxt;
    logic osc_good_r;
    logic osc_good_nxt;

    // external clock divider
    logic [1:0] sel_pins;
    logic gate_ok;
    logic [1:0] req_sel;
    logic [1:0] cur_sel_r;
    logic [1:0] cur_sel_nxt;
    logic [3:0] half_cnt_r;
    logic [3:0] half_cnt_nxt;
    logic ext_clk_r;
    logic ext_clk_nxt;
    logic half_done;

    // base and range ticks
    logic [1:0] rate_range;
    logic [4:0] base_cnt_r;
    logic [4:0] base_cnt_nxt;
    logic base_wrap;
    logic base_tick_r;
    logic [2:0] range_cnt_r;
    logic [2:0] range_cnt_nxt;
    logic [2:0] range_len_m1;
    logic range_wrap;
    logic range_tick_r;

    // feedback divider
    logic [4:0] fb_cnt_r;
    logic [4:0] fb_cnt_nxt;
    logic [4:0] fb_len_m1;
    logic fb_wrap;
    logic fb_tick_r;

    // registers and bus
    logic [1:0] ctrl_r;
    logic variant_433;
    logic allow_ext;
    status_t status;
    logic apb_setup;
    logic ctrl_hit;
    logic stat_hit;
    logic addr_hit;
    logic ctrl_wr;
    logic [31:0] rdata;
    logic [31:0] prdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic rx_path_r;

    // half period of the external clock in system clocks, minus one
    function automatic logic [3:0] half_m1(input logic [1:0] sel);
        logic [3:0] h;
        h = HALF_HI_M1;
        case (sel)
            SEL_DIV_LO: h = HALF_LO_M1;
            SEL_DIV_MID: h = HALF_MID_M1;
            default: h = HALF_HI_M1;
        endcase
        return h;
    endfunction : half_m1

    // ---------------- power mode ----------------
    // receive-enable alone is taken as active
    always_comb begin
        mode_nxt = MODE_STANDBY;
        if (!rx_en_i && !enable_i) begin
            mode_nxt = MODE_OFF;
        end else if (rx_en_i) begin
            mode_nxt = MODE_ACTIVE;
        end else begin
            mode_nxt = MODE_STANDBY;
        end
    end

    // everything but the bus stops with the oscillator
    assign osc_on = (mode_r != MODE_OFF);

    // receive path follows the mode in the same cycle as the mode register
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_r <= MODE_OFF;
            rx_path_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            rx_path_r <= (mode_nxt == MODE_ACTIVE);
        end
    end

    // ---------------- oscillator start-up ----------------
    // a stopped oscillator loses its amplitude at once
    // the count freezes once good so it never wraps
    assign osc_cnt_nxt = !osc_on ? 16'h0000 :
                         osc_good_r ? osc_cnt_r : osc_cnt_r + 16'h0001;
    assign osc_good_nxt = osc_on &&
                          (osc_good_r || (osc_cnt_r == OSC_GOOD_CLKS_P - 16'h0001));

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            osc_cnt_r <= 16'h0000;
            osc_good_r <= 1'b0;
        end else begin
            osc_cnt_r <= osc_cnt_nxt;
            osc_good_r <= osc_good_nxt;
        end
    end

    // ---------------- external clock ----------------
    assign sel_pins = {ext_div_sel1_i, ext_div_sel0_i};
    // release needs amplitude, logic supply and the software allow bit
    assign gate_ok = osc_on && osc_good_r && logic_supply_ok_i && allow_ext;
    assign req_sel = gate_ok ? sel_pins : SEL_OFF;
    // a zero count marks the last cycle of a half
    assign half_done = (half_cnt_r == 4'h0);

    // a high half completes unless the oscillator stops, and the low half that follows
    // uses the same ratio; new codes are taken only at the end of a low half
    always_comb begin
        ext_clk_nxt = ext_clk_r;
        cur_sel_nxt = cur_sel_r;
        half_cnt_nxt = half_cnt_r;
        if (!osc_on) begin
            ext_clk_nxt = 1'b0;
            cur_sel_nxt = SEL_OFF;
            half_cnt_nxt = 4'h0;
        end else if (!half_done) begin
            half_cnt_nxt = half_cnt_r - 4'h1;
        end else if (ext_clk_r) begin
            ext_clk_nxt = 1'b0;
            half_cnt_nxt = half_m1(cur_sel_r);
        end else if (req_sel != SEL_OFF) begin
            ext_clk_nxt = 1'b1;
            cur_sel_nxt = req_sel;
            half_cnt_nxt = half_m1(req_sel);
        end else begin
            ext_clk_nxt = 1'b0;
            cur_sel_nxt = SEL_OFF;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // clock low, no ratio latched
            ext_clk_r <= 1'b0;
            cur_sel_r <= SEL_OFF;
            half_cnt_r <= 4'h0;
        end else begin
            ext_clk_r <= ext_clk_nxt;
            cur_sel_r <= cur_sel_nxt;
            half_cnt_r <= half_cnt_nxt;
        end
    end

    // ---------------- base tick ----------------
    // one base tick every 16 reference cycles, two system clocks each
    assign base_wrap = osc_on && (base_cnt_r == BASE_LAST);
    assign base_cnt_nxt = !osc_on ? 5'h00 :
                          base_wrap ? 5'h00 : base_cnt_r + 5'h01;

    // ---------------- range tick ----------------
    // rate pins are taken as synchronous and used live
    assign rate_range = {rate_sel1_i, rate_sel0_i};
    // length of one range tick in base ticks, minus one
    assign range_len_m1 = (rate_range == 2'h0) ? RANGE0_M1 :
                          (rate_range == 2'h1) ? RANGE1_M1 :
                          (rate_range == 2'h2) ? RANGE2_M1 : RANGE3_M1;
    // a shorter range taking effect with the count at or past its last value wraps at the next base tick
    assign range_wrap = base_wrap && (range_cnt_r >= range_len_m1);
    assign range_cnt_nxt = !osc_on ? 3'h0 :
                           range_wrap ? 3'h0 :
                           base_wrap ? range_cnt_r + 3'h1 : range_cnt_r;

    // both ticks are registered so they line up on the same cycle
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            base_cnt_r <= 5'h00;
            base_tick_r <= 1'b0;
            range_cnt_r <= 3'h0;
            range_tick_r <= 1'b0;
        end else begin
            base_cnt_r <= base_cnt_nxt;
            base_tick_r <= base_wrap;
            range_cnt_r <= range_cnt_nxt;
            range_tick_r <= range_wrap;
        end
    end

    // ---------------- feedback divider ----------------
    // counts local oscillator ticks; held at zero outside active mode
    assign fb_len_m1 = variant_433 ? FB_DIV_433_M1 : FB_DIV_315_M1;
    assign fb_wrap = local_osc_tick_i && (fb_cnt_r >= fb_len_m1);
    assign fb_cnt_nxt = (mode_r != MODE_ACTIVE) ? 5'h00 :
                        fb_wrap ? 5'h00 :
                        local_osc_tick_i ? fb_cnt_r + 5'h01 : fb_cnt_r;

    // one pulse per full feedback count, the phase compare point
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fb_cnt_r <= 5'h00;
            fb_tick_r <= 1'b0;
        end else begin
            fb_cnt_r <= fb_cnt_nxt;
            fb_tick_r <= fb_wrap && (mode_r == MODE_ACTIVE);
        end
    end

    // ---------------- apb registers ----------------
    // control bits: feedback variant and external clock allow
    assign variant_433 = ctrl_r[CTRL_VARIANT_BIT];
    assign allow_ext = ctrl_r[CTRL_ALLOW_BIT];

    // status is a live view of the clock state, nothing is captured
    assign status.osc_good = osc_good_r;
    assign status.supply_ok = logic_supply_ok_i;
    assign status.ext_running = (cur_sel_r != SEL_OFF);
    assign status.mode = mode_r;
    assign status.rate_range = rate_range;
    assign status.cur_sel = cur_sel_r;

    // decode on the setup cycle; the access cycle only commits writes
    assign apb_setup = psel_i && !penable_i;
    assign ctrl_hit = (paddr_i == CTRL_ADDR);
    assign stat_hit = (paddr_i == STAT_ADDR);
    assign addr_hit = ctrl_hit || stat_hit;
    assign ctrl_wr = psel_i && penable_i && pready_r && pwrite_i && ctrl_hit;

    // unmapped offsets read as zero
    always_comb begin
        rdata = 32'h0000_0000;
        if (ctrl_hit) begin
            rdata = {30'h0000_0000, ctrl_r};
        end else if (stat_hit) begin
            rdata = {{(32 - $bits(status_t)){1'b0}}, status};
        end
    end

    // read data is driven only for the one ready cycle
    assign prdata_nxt = (apb_setup && !pwrite_i) ? rdata : 32'h0000_0000;

    // one wait-free access cycle: ready is raised for the cycle after setup
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= apb_setup;
            pslverr_r <= apb_setup && !addr_hit;
            prdata_r <= prdata_nxt;
        end
    end

    // status writes land nowhere and raise no error
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r <= CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_r <= pwdata_i[1:0];
        end
    end

    // ---------------- outputs ----------------
    // every output but crystal_osc_en_o is a register; that one is decoded from mode_r
    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign crystal_osc_en_o = (mode_r != MODE_OFF);
    assign osc_amplitude_good_o = osc_good_r;
    assign rx_path_en_o = rx_path_r;
    assign ext_clk_o = ext_clk_r;
    assign base_tick_o = base_tick_r;
    assign range_tick_o = range_tick_r;
    assign fb_tick_o = fb_tick_r;

endmodule : rx_clock_generation

// File: inc/rx_clk_pkg.sv
// constants, types and register map of the receiver clock generation block
package rx_clk_pkg;
    // clock and reference timing
    localparam int unsigned CLK_PERIOD_NS = 40;
    // the reference runs at half the system clock rate
    localparam int unsigned REF_CLKS = 2;
    // base tick is reference divided by 16
    localparam int unsigned BASE_DIV = 16;
    localparam int unsigned BASE_CLKS = BASE_DIV * REF_CLKS;
    localparam logic [4:0] BASE_LAST = 5'(BASE_CLKS - 1);

    // oscillator start-up: time constant and multiple until amplitude good
    localparam int unsigned OSC_TAU_NS = 2000;
    localparam int unsigned OSC_GOOD_TAUS = 15;
    localparam int unsigned OSC_GOOD_CLKS =
        (OSC_TAU_NS * OSC_GOOD_TAUS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // external clock division ratios, in reference cycles
    localparam int unsigned EXT_DIV_LO = 3;
    localparam int unsigned EXT_DIV_MID = 6;
    localparam int unsigned EXT_DIV_HI = 12;
    localparam logic [3:0] HALF_LO_M1 = 4'(EXT_DIV_LO * REF_CLKS / 2 - 1);
    localparam logic [3:0] HALF_MID_M1 = 4'(EXT_DIV_MID * REF_CLKS / 2 - 1);
    localparam logic [3:0] HALF_HI_M1 = 4'(EXT_DIV_HI * REF_CLKS / 2 - 1);

    // divider select codes
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_DIV_LO = 2'h1;
    localparam logic [1:0] SEL_DIV_MID = 2'h2;
    localparam logic [1:0] SEL_DIV_HI = 2'h3;

    // range tick length in base ticks, minus one, for ranges 0..3
    localparam logic [2:0] RANGE0_M1 = 3'h7;
    localparam logic [2:0] RANGE1_M1 = 3'h3;
    localparam logic [2:0] RANGE2_M1 = 3'h1;
    localparam logic [2:0] RANGE3_M1 = 3'h0;

    // synthesizer feedback division
    localparam logic [4:0] FB_DIV_315_M1 = 5'(24 - 1);
    localparam logic [4:0] FB_DIV_433_M1 = 5'(32 - 1);

    // register map
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] STAT_ADDR = 8'h04;
    localparam int unsigned CTRL_VARIANT_BIT = 0;
    localparam int unsigned CTRL_ALLOW_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;

    // power modes, one-hot
    typedef enum logic [2:0] {
        MODE_OFF = 3'b001,
        MODE_STANDBY = 3'b010,
        MODE_ACTIVE = 3'b100
    } power_mode_t;

    // status register layout, low bits
    typedef struct packed {
        logic osc_good;
        logic supply_ok;
        logic ext_running;
        logic [2:0] mode;
        logic [1:0] rate_range;
        logic [1:0] cur_sel;
    } status_t;
endpackage : rx_clk_pkg

// File: tb/rx_mcu_model.sv
// microcontroller model: drives select and rate pins, times the external clock
`timescale 1ns/1ns
module rx_mcu_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // bench commands
    input wire logic [1:0] sel_cmd_i,
    input wire logic [1:0] rate_cmd_i,
    // receiver pins
    input wire logic ext_clk_i,
    output logic ext_div_sel0_o,
    output logic ext_div_sel1_o,
    output logic rate_sel0_o,
    output logic rate_sel1_o,
    // observed clock
    output logic [7:0] period_o,
    output logic [15:0] rises_o
);
    logic ext_q_r;
    logic [7:0] cnt_r;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {ext_div_sel1_o, ext_div_sel0_o, rate_sel1_o, rate_sel0_o} <= 4'h0;
            {ext_q_r, cnt_r, period_o, rises_o} <= '0;
        end else begin
            {ext_div_sel1_o, ext_div_sel0_o} <= sel_cmd_i;
            {rate_sel1_o, rate_sel0_o} <= rate_cmd_i;
            ext_q_r <= ext_clk_i;
            if (ext_clk_i && !ext_q_r) begin
                period_o <= cnt_r;
                cnt_r <= 8'h01;
                rises_o <= rises_o + 16'h0001;
            end else begin
                cnt_r <= cnt_r + 8'(cnt_r != 8'hFF);
            end
        end
    end
endmodule : rx_mcu_model

// File: tb/rx_clk_sva.sv
// assertions on the receiver clock generation ports
`timescale 1ns/1ns
module rx_clk_sva
    import rx_clk_pkg::*;
#(
    parameter logic [15:0] OSC_GOOD_CLKS_P = 16'(OSC_GOOD_CLKS)
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // pins
    input wire logic logic_supply_ok_i,
    input wire logic ext_div_sel0_i,
    input wire logic ext_div_sel1_i,
    input wire logic rate_sel0_i,
    input wire logic rate_sel1_i,
    // outputs
    input wire logic crystal_osc_en_o,
    input wire logic osc_amplitude_good_o,
    input wire logic rx_path_en_o,
    input wire logic ext_clk_o,
    input wire logic base_tick_o,
    input wire logic range_tick_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    logic [1:0] sel_q_r, per_sel_r, rate_q_r;
    logic ext_q_r, bt_seen_r, rt_seen_r;
    logic [7:0] run_r, bt_gap_r;
    logic [4:0] lo_need_r;
    logic [3:0] rt_cnt_r;
    logic [15:0] on_cnt_r;
    wire logic [1:0] sel_w = {ext_div_sel1_i, ext_div_sel0_i};
    wire logic [1:0] rate_w = {rate_sel1_i, rate_sel0_i};
    wire logic [4:0] half_w = per_sel_r == 2'h1 ? 5'h03 : per_sel_r == 2'h2 ? 5'h06 : 5'h0C;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {sel_q_r, per_sel_r, rate_q_r, ext_q_r, bt_seen_r, rt_seen_r} <= '0;
            {run_r, bt_gap_r, lo_need_r, rt_cnt_r, on_cnt_r} <= '0;
        end else begin
            sel_q_r <= sel_w;
            rate_q_r <= rate_w;
            ext_q_r <= ext_clk_o;
            run_r <= (ext_clk_o == ext_q_r) ? run_r + 8'(run_r != 8'hFF) : 8'h01;
            if (ext_clk_o && !ext_q_r) per_sel_r <= sel_q_r;
            if (!ext_clk_o && ext_q_r) lo_need_r <= half_w;
            on_cnt_r <= crystal_osc_en_o ? on_cnt_r + 16'(on_cnt_r != 16'hFFFF) : 16'h0;
            bt_gap_r <= base_tick_o ? 8'h01 : bt_gap_r + 8'(bt_gap_r != 8'hFF);
            bt_seen_r <= crystal_osc_en_o && (bt_seen_r || base_tick_o);
            rt_cnt_r <= range_tick_o ? 4'h1 : rt_cnt_r + 4'(base_tick_o);
            rt_seen_r <= crystal_osc_en_o && rate_w == rate_q_r && (rt_seen_r || range_tick_o);
        end
    end
    a_off_quiet: assert property (!crystal_osc_en_o [*2] |->
        !osc_amplitude_good_o && !ext_clk_o && !base_tick_o) else $error("activity while off");
    a_release_gate: assert property ($rose(ext_clk_o) |->
        $past(osc_amplitude_good_o && logic_supply_ok_i)) else $error("clock without gate");
    a_sel_off_low: assert property ($rose(ext_clk_o) |->
        sel_q_r != 2'h0 || $past(sel_w, 2) != 2'h0) else $error("clock started on code 00");
    a_high_len: assert property ($fell(ext_clk_o) |-> run_r == 8'(half_w))
        else $error("high half wrong length");
    a_low_len: assert property ($rose(ext_clk_o) |-> run_r >= 8'(lo_need_r))
        else $error("low half cut short");
    a_good_delay: assert property ($rose(osc_amplitude_good_o) |->
        on_cnt_r == OSC_GOOD_CLKS_P) else $error("oscillator good at wrong time");
    a_base_gap: assert property (base_tick_o && bt_seen_r |-> bt_gap_r == 8'h20)
        else $error("base tick spacing wrong");
    a_range_gap: assert property (range_tick_o && rt_seen_r |->
        rt_cnt_r == 4'h8 >> rate_w) else $error("range tick spacing wrong");
    a_range_on_base: assert property (range_tick_o |-> base_tick_o)
        else $error("range tick off base tick");
    a_rx_path_mode: assert property (rx_path_en_o |-> crystal_osc_en_o)
        else $error("receive path without oscillator");
    c_slow_clock: cover property ($fell(ext_clk_o) && per_sel_r == 2'h3);
    c_osc_good: cover property ($rose(osc_amplitude_good_o));
    c_range_slow: cover property (range_tick_o && rt_seen_r && rate_w == 2'h0);
endmodule : rx_clk_sva

bind rx_clock_generation rx_clk_sva #(.OSC_GOOD_CLKS_P(OSC_GOOD_CLKS_P)) u_sva (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .logic_supply_ok_i(logic_supply_ok_i),
    .ext_div_sel0_i(ext_div_sel0_i), .ext_div_sel1_i(ext_div_sel1_i),
    .rate_sel0_i(rate_sel0_i), .rate_sel1_i(rate_sel1_i), .crystal_osc_en_o(crystal_osc_en_o),
    .osc_amplitude_good_o(osc_amplitude_good_o), .rx_path_en_o(rx_path_en_o),
    .ext_clk_o(ext_clk_o), .base_tick_o(base_tick_o), .range_tick_o(range_tick_o));

// File: tb/rx_clock_generation_tb.sv
// self-checking bench for the receiver clock generation block
`timescale 1ns/1ns
module rx_clock_generation_tb;
    import rx_clk_pkg::*;
    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, rx_en = 0, enable = 0;
    logic supply_ok = 1, lo_tick = 0, s0, s1, r0, r1, err, pready, pslverr;
    logic fb_tick, osc_en, good, rx_path, ext_clk, base_tick, range_tick;
    logic [7:0] paddr = 8'h00, period;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [1:0] sel_cmd = 2'h0, rate_cmd = 2'h0;
    logic [15:0] rises, m;
    status_t st;
    int miscompares = 0, comparisons = 0, n;
    rx_clock_generation #(.OSC_GOOD_CLKS_P(16'h0008)) DUT (
        .clk_i(clk), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .rx_en_i(rx_en), .enable_i(enable),
        .logic_supply_ok_i(supply_ok), .ext_div_sel0_i(s0), .ext_div_sel1_i(s1),
        .rate_sel0_i(r0), .rate_sel1_i(r1), .local_osc_tick_i(lo_tick), .fb_tick_o(fb_tick),
        .crystal_osc_en_o(osc_en), .osc_amplitude_good_o(good), .rx_path_en_o(rx_path),
        .ext_clk_o(ext_clk), .base_tick_o(base_tick), .range_tick_o(range_tick));
    rx_mcu_model mcu (
        .clk_i(clk), .reset_n_i(reset_n), .sel_cmd_i(sel_cmd), .rate_cmd_i(rate_cmd),
        .ext_clk_i(ext_clk), .ext_div_sel0_o(s0), .ext_div_sel1_o(s1), .rate_sel0_o(r0),
        .rate_sel1_o(r1), .period_o(period), .rises_o(rises));
    always #20 clk = ~clk;
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do begin @(posedge clk); i++; end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task gap(input logic fb);
        int i;
        i = 0;
        n = 0;
        do begin @(negedge clk); i++; end while ((fb ? fb_tick : range_tick) !== 1'b1 && i < 600);
        do begin @(negedge clk); n++; end while ((fb ? fb_tick : range_tick) !== 1'b1 && n < 600);
    endtask : gap
    task done(input string nm);
        $display("test %s finished", nm);
    endtask : done
    task end_sim;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        end_sim;
    end
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1;
        apb(0, CTRL_ADDR, 32'h0);
        chk("ctrl reset", 32'(CTRL_RESET), rd);
        st = '0;
        st.supply_ok = 1'b1;
        st.mode = MODE_OFF;
        apb(0, STAT_ADDR, 32'h0);
        chk("status reset", 32'(st), rd);
        apb(0, 8'h08, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], err});
        done("reset");
        enable <= 1;
        repeat (20) @(posedge clk);
        chk("standby pins", 32'h6, 32'({osc_en, good, rx_path}));
        for (int k = 1; k < 4; k++) begin
            sel_cmd <= 2'(k);
            repeat (80) @(posedge clk);
            chk("ext period", 32'(6 << (k - 1)), 32'(period));
        end
        rx_en <= 1;
        lo_tick <= 1;
        repeat (80) @(posedge clk);
        chk("active period", 32'h118, {23'h0, rx_path, period});
        gap(1);
        gap(1);
        chk("fb div 24", 32'h18, 32'(n));
        apb(1, CTRL_ADDR, 32'h3);
        gap(1);
        gap(1);
        chk("fb div 32", 32'h20, 32'(n));
        done("clocks");
        @(posedge clk);
        supply_ok <= 0;
        repeat (40) @(posedge clk);
        m = rises;
        repeat (80) @(posedge clk);
        chk("supply gate", 32'(m), 32'(rises));
        supply_ok <= 1;
        apb(1, CTRL_ADDR, 32'h1);
        m = rises;
        repeat (80) @(posedge clk);
        chk("allow gate", 32'(m), 32'(rises));
        apb(1, CTRL_ADDR, 32'h3);
        repeat (60) @(posedge clk);
        chk("released", 32'h1, 32'(rises != m));
        sel_cmd <= 2'h0;
        repeat (40) @(posedge clk);
        m = rises;
        repeat (80) @(posedge clk);
        chk("code off", {16'h0, m}, {15'h0, ext_clk, rises});
        done("gating");
        for (int r = 0; r < 4; r++) begin
            gap(0);
            @(posedge clk);
            rate_cmd <= 2'(r);
            gap(0);
            gap(0);
            chk("range tick", 32'(32 * (8 >> r)), 32'(n));
        end
        @(posedge clk);
        rx_en <= 0;
        enable <= 0;
        repeat (4) @(posedge clk);
        chk("off mode", 32'h0, 32'({osc_en, good, rx_path, ext_clk, base_tick}));
        done("ticks and off");
        end_sim;
    end
endmodule : rx_clock_generation_tb
